/* File: core/rhc_row_ctrl.sv */
// Behaviour
// - One controller serves 42 hit inputs and stores hit locations locally.
// - A column has 168 such rows; four columns form the array.
// - All hit inputs are sampled into latch-hold cells before processing.
// - Inputs form banks of six; any hit raises that bank's flag.
// - A scan steps through seven bank codes, examining each flag.
// - Set bank writes pattern, bank code and timestamp to next free slot.
// - Bidirectional slot register advances one place per stored pattern.
// - Readout steps the slot register backwards over valid slots only.
// - Nineteen slots hold hit records.
// - Row address is read out together with each hit record.
// - Slot chain uses the common three-phase cell with active-low clear.
// - Cell states: reset 0101, hold 1010, transfer 0100.
// - Park low holds latched hits; park high, freeze low is safe state.
// - Shaping pixel gives one hit pulse per event.
// - Sampling pixel flags a hit then self-resets before the next.
// - Sampling pixel self-reset runs at the logic clock rate.
`timescale 1ns/1ps
`default_nettype none

module rhc_row_ctrl
    import rhc_pkg::*;
#(
    parameter int                   PIXELS    = RHC_PIXELS,
    parameter int                   SLOTS     = RHC_SLOTS,
    parameter int                   ROWS      = RHC_ROWS,
    parameter logic [RHC_ROW_W-1:0] ROW_INDEX = 8'h00
) (
    input  wire logic               clk,            // 25 MHz logic clock.
    input  wire logic               rst,            // Asynchronous reset, active high.
    input  wire logic               psel,           // APB select.
    input  wire logic               penable,        // APB access phase.
    input  wire logic               pwrite,         // APB write when high.
    input  wire logic [7:0]         paddr,          // APB byte address.
    input  wire logic [31:0]        pwdata,         // APB write data.
    output logic      [31:0]        prdata,         // APB read data.
    output logic                    pready,         // APB ready.
    output logic                    pslverr,        // APB error on unmapped address.
    input  wire logic [PIXELS-1:0]  hit_in,         // Pixel hit flags.
    input  wire logic [RHC_TS_W-1:0] timestamp,     // Global timestamp.
    input  wire logic               latch_freeze_low, // Latch freeze, active low.
    input  wire logic               latch_park_high,  // Latch park to safe state.
    input  wire rhc_phase_s         slot_phase,     // Slot chain phases and clear.
    output rhc_out_s                rd_word,        // Readout word.
    output logic                    rd_valid        // One-cycle pulse with rd_word.
);

    localparam int NBANK = PIXELS / RHC_BANK_W;

    logic [PIXELS-1:0]       lat_r, lat_nxt;
    logic [NBANK-1:0]        flag;
    logic [SLOTS-1:0]        ptr_r, ptr_nxt;
    logic [RHC_FILL_W-1:0]   fill_r, fill_nxt;
    rhc_rec_s                mem_r [SLOTS];
    logic [SLOTS-1:0]        wr_sel;
    rhc_state_e              st_r, st_nxt;
    logic [RHC_CODE_W-1:0]   bank_r, bank_nxt;
    logic                    wr_go;
    logic                    one_d_r;
    logic                    step;
    logic                    chain_clear;
    logic                    ovfl_r, ovfl_nxt;
    logic                    fault_r, fault_nxt;
    logic                    read_mode_r, read_mode_nxt;
    logic                    scan_go;
    logic                    acc;
    logic [31:0]             prdata_nxt;
    logic                    pready_nxt;
    logic                    pslverr_nxt;
    rhc_out_s                rd_word_nxt;
    logic                    rd_valid_nxt;
    rhc_rec_s                top_rec;

    // logic-clock sampling
    // Hits are OR-ed in while the freeze is released, so a one-cycle pulse
    // is never missed; park high clears, since the hold state is undefined.
    always_comb begin
        if (latch_park_high) begin
            lat_nxt = '0;
        end else if (latch_freeze_low) begin
            lat_nxt = lat_r | hit_in;
        end else begin
            lat_nxt = lat_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lat_r <= '0;
        end else begin
            lat_r <= lat_nxt;
        end
    end

    genvar b;
    generate
        for (b = 0; b < NBANK; b++) begin : g_bank
            assign flag[b] = |lat_r[b*RHC_BANK_W +: RHC_BANK_W];
        end
    endgenerate

    // Only a transition into the hold state (1,0,1) counts as one chain step;
    // the clear is honoured only while phase two is high and phase three low.
    // cell states
    assign step        = slot_phase.one && !one_d_r && !slot_phase.two && slot_phase.three;
    assign chain_clear = !slot_phase.clear_low && slot_phase.two && !slot_phase.three;

    assign scan_go = acc && pwrite && (paddr == RHC_CTRL_OFS) && pwdata[RHC_CTRL_SCAN_BIT];
    assign wr_go   = (st_r == RHC_SCAN) && flag[bank_r] && !ptr_r[SLOTS-1];

    always_comb begin
        st_nxt   = st_r;
        bank_nxt = bank_r;
        case (st_r)
            RHC_IDLE: begin
                if (scan_go && !read_mode_r) begin
                    st_nxt   = RHC_SCAN;
                    bank_nxt = '0;
                end
            end
            RHC_SCAN: begin
                if (bank_r == RHC_CODE_W'(NBANK - 1)) begin
                    st_nxt = RHC_IDLE;
                end else begin
                    bank_nxt = bank_r + 1'b1;
                end
            end
            default: begin
                st_nxt = RHC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r   <= RHC_IDLE;
            bank_r <= '0;
        end else begin
            st_r   <= st_nxt;
            bank_r <= bank_nxt;
        end
    end

    // active-low chain clear
    // The slot register is a thermometer: set bits mark filled slots.
    always_comb begin
        ptr_nxt  = ptr_r;
        fill_nxt = fill_r;
        if (chain_clear) begin
            ptr_nxt  = '0;
            fill_nxt = '0;
        end else if (wr_go) begin
            ptr_nxt  = {ptr_r[SLOTS-2:0], 1'b1};
            fill_nxt = fill_r + 1'b1;
        end else if (step && read_mode_r && ptr_r[0]) begin
            ptr_nxt  = {1'b0, ptr_r[SLOTS-1:1]};
            fill_nxt = fill_r - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr_r   <= '0;
            fill_r  <= '0;
            one_d_r <= 1'b1;  // Phase one idles high, so release gives no false step.
        end else begin
            ptr_r   <= ptr_nxt;
            fill_r  <= fill_nxt;
            one_d_r <= slot_phase.one;
        end
    end

    // local records
    // The free slot is the lowest one still clear in the thermometer.
    genvar s;
    generate
        for (s = 0; s < SLOTS; s++) begin : g_slot
            if (s == 0) begin : g_first
                assign wr_sel[s] = wr_go && !ptr_r[0] && !chain_clear;
            end else begin : g_rest
                assign wr_sel[s] = wr_go && !ptr_r[s] && ptr_r[s-1] && !chain_clear;
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    mem_r[s] <= '0;
                end else if (wr_sel[s]) begin
                    mem_r[s] <= '{stamp: timestamp, bank: bank_r, pattern:
                                  lat_r[bank_r*RHC_BANK_W +: RHC_BANK_W]};
                end
            end
        end
    endgenerate

    // The newest valid slot is the top set bit; it leaves first on readout.
    always_comb begin
        top_rec = '0;
        for (int i = 0; i < SLOTS; i++) begin
            if (ptr_r[i] && (i == SLOTS - 1 || !ptr_r[(i + 1) % SLOTS])) begin
                top_rec = mem_r[i];
            end
        end
    end

    always_comb begin
        rd_word_nxt  = rd_word;
        rd_valid_nxt = 1'b0;
        if (step && read_mode_r && ptr_r[0] && !chain_clear && !wr_go) begin
            rd_word_nxt  = '{row: ROW_INDEX, rec: top_rec};
            rd_valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_word  <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_word  <= rd_word_nxt;
            rd_valid <= rd_valid_nxt;
        end
    end

    // APB slave with one wait state: pready rises in the second access cycle,
    // and writes take effect only on the edge that samples it high.
    assign acc = psel && penable && pready;

    always_comb begin
        read_mode_nxt = read_mode_r;
        ovfl_nxt      = ovfl_r;
        fault_nxt     = fault_r;
        if (acc && pwrite && (paddr == RHC_CTRL_OFS)) begin
            read_mode_nxt = pwdata[RHC_CTRL_READ_BIT];
        end
        if (acc && pwrite && (paddr == RHC_CLEAR_OFS)) begin
            ovfl_nxt  = ovfl_r & ~pwdata[RHC_STAT_OVFL_BIT];
            fault_nxt = fault_r & ~pwdata[RHC_STAT_FAULT_BIT];
        end
        // Set wins over a clear in the same cycle.
        // overflow noted
        if ((st_r == RHC_SCAN) && flag[bank_r] && ptr_r[SLOTS-1]) begin
            ovfl_nxt = 1'b1;
        end
        if (slot_phase.three && !slot_phase.clear_low) begin
            fault_nxt = 1'b1;
        end
    end

    always_comb begin
        pready_nxt  = psel && penable && !pready;
        prdata_nxt  = '0;
        pslverr_nxt = 1'b0;
        if (pready_nxt) begin
            if (paddr == RHC_CTRL_OFS) begin
                prdata_nxt[RHC_CTRL_READ_BIT] = read_mode_r;
            end else if (paddr == RHC_STAT_OFS) begin
                prdata_nxt[RHC_STAT_FILL_LSB +: RHC_FILL_W] = fill_r;
                prdata_nxt[RHC_STAT_BUSY_BIT]  = (st_r == RHC_SCAN);
                prdata_nxt[RHC_STAT_OVFL_BIT]  = ovfl_r;
                prdata_nxt[RHC_STAT_FAULT_BIT] = fault_r;
                prdata_nxt[RHC_STAT_READ_BIT]  = read_mode_r;
            end else if (paddr == RHC_CLEAR_OFS) begin
                prdata_nxt = '0;
            end else if (paddr == RHC_ROWID_OFS) begin
                prdata_nxt[RHC_ROW_W-1:0] = ROW_INDEX;
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_mode_r <= RHC_CTRL_RESET[RHC_CTRL_READ_BIT];
            ovfl_r      <= 1'b0;
            fault_r     <= 1'b0;
            prdata      <= '0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            read_mode_r <= read_mode_nxt;
            ovfl_r      <= ovfl_nxt;
            fault_r     <= fault_nxt;
            prdata      <= prdata_nxt;
            pready      <= pready_nxt;
            pslverr     <= pslverr_nxt;
        end
    end

endmodule

`default_nettype wire

/* File: core/rhc_pkg.sv */
package rhc_pkg;

    // Array geometry of one row controller and of the whole sensing area.
    localparam int RHC_PIXELS  = 42;
    localparam int RHC_BANK_W  = 6;
    localparam int RHC_BANKS   = 7;
    localparam int RHC_SLOTS   = 19;
    localparam int RHC_ROWS    = 168;
    localparam int RHC_COLUMNS = 4;
    localparam int RHC_TS_W    = 13;
    localparam int RHC_ROW_W   = 8;
    localparam int RHC_CODE_W  = 3;
    localparam int RHC_FILL_W  = 5;

    // Register byte offsets on the APB port.
    localparam logic [7:0] RHC_CTRL_OFS  = 8'h00;
    localparam logic [7:0] RHC_STAT_OFS  = 8'h04;
    localparam logic [7:0] RHC_CLEAR_OFS = 8'h08;
    localparam logic [7:0] RHC_ROWID_OFS = 8'h0c;

    // Control register fields and reset value.
    localparam int          RHC_CTRL_SCAN_BIT = 0;
    localparam int          RHC_CTRL_READ_BIT = 1;
    localparam logic [31:0] RHC_CTRL_RESET    = 32'h0000_0000;

    // Status register field positions.
    localparam int RHC_STAT_FILL_LSB  = 0;
    localparam int RHC_STAT_BUSY_BIT  = 8;
    localparam int RHC_STAT_OVFL_BIT  = 9;
    localparam int RHC_STAT_FAULT_BIT = 10;
    localparam int RHC_STAT_READ_BIT  = 11;

    // One stored hit record: 22 bits of slot storage.
    typedef struct packed {
        logic [RHC_TS_W-1:0]   stamp;
        logic [RHC_CODE_W-1:0] bank;
        logic [RHC_BANK_W-1:0] pattern;
    } rhc_rec_s;

    // Parallel readout word: row address ROM beside the record, 30 bits.
    typedef struct packed {
        logic [RHC_ROW_W-1:0] row;
        rhc_rec_s             rec;
    } rhc_out_s;

    // Three-phase chain controls as seen at the pins.
    typedef struct packed {
        logic one;
        logic two;
        logic three;
        logic clear_low;
    } rhc_phase_s;

    typedef enum logic [1:0] {
        RHC_IDLE = 2'b01,
        RHC_SCAN = 2'b10
    } rhc_state_e;

endpackage

/* File: tb/rhc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module rhc_props
    import rhc_pkg::*;
#(
    parameter logic [RHC_ROW_W-1:0] ROW_INDEX = 8'h00
) (
    input wire logic        clk,        // Clock.
    input wire logic        rst,        // Reset.
    input wire logic        psel,       // Select.
    input wire logic        penable,    // Access.
    input wire logic [31:0] prdata,     // Read data.
    input wire logic        pready,     // Ready.
    input wire logic        pslverr,    // Error.
    input wire rhc_phase_s  slot_phase, // Chain pins.
    input wire rhc_out_s    rd_word,    // Readout word.
    input wire logic        rd_valid    // Readout strobe.
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // The bus setup cycle and the phase levels of a readout step (one high, two low, three high).
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_step;
        slot_phase.one && !slot_phase.two && slot_phase.three;
    endsequence
    a_ready_one_wait: assert property (s_setup |=> !pready ##1 pready) else $error("late ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
    a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
    a_valid_pulse: assert property (rd_valid |=> !rd_valid) else $error("long valid");
    a_valid_cause: assert property (rd_valid |-> $past(slot_phase.one && !slot_phase.two
        && slot_phase.three) && !$past(slot_phase.one, 2)) else $error("valid without step");
    a_row_rom: assert property (rd_valid |-> rd_word.row == ROW_INDEX) else $error("row");
    a_bank_code: assert property (rd_valid |-> rd_word.rec.bank < 3'h7) else $error("bank");
    a_bank_set: assert property (rd_valid |-> rd_word.rec.pattern != 6'h0)
        else $error("empty record");
    a_word_holds: assert property ($changed(rd_word) |-> rd_valid) else $error("word moved");
    c_step: cover property (s_step ##1 rd_valid);
endmodule
bind rhc_row_ctrl rhc_props #(.ROW_INDEX(ROW_INDEX)) u_rhc_props (.clk, .rst, .psel,
    .penable, .prdata, .pready, .pslverr, .slot_phase, .rd_word, .rd_valid);
`default_nettype wire

/* File: tb/rhc_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module rhc_seq
    import rhc_pkg::*;
(
    input  wire logic     clk,  // Logic clock.
    input  wire logic     rst,  // Reset, active high.
    input  wire logic     step, // Request one readout step.
    input  wire logic     clr,  // Request a chain clear.
    output var rhc_phase_s ph,  // Phases to the slot chain.
    output logic          busy  // High outside the parked hold state.
);
    logic [3:0] st_r;
    // Only the parked hold state takes new requests.
    assign busy = (st_r != 4'h5);
    // One pin moves per cycle, which gives far more edge spacing than needed.
    // edge spacing kept.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph   <= '{one: 1'h1, two: 1'h1, three: 1'h0, clear_low: 1'h0};
            st_r <= 4'h0;
        end else begin
            case (st_r)
                4'h0: ph.one <= 1'h0;
                4'h1: ph.clear_low <= 1'h1;
                4'h2: ph.two <= 1'h0;
                4'h3: ph.three <= 1'h1;
                4'h4: ph.one <= 1'h1;
                4'h6: ph.one <= 1'h1;
                4'h7: ph.three <= 1'h0;
                4'h8: ph.two <= 1'h1;
                4'h9: ph.clear_low <= 1'h0;
                default: if (step || clr) ph.one <= 1'h0;
            endcase
            st_r <= st_r == 4'h5 ? (step ? 4'h6 : clr ? 4'h7 : 4'h5)
                  : st_r == 4'h6 ? 4'h5 : st_r == 4'h9 ? 4'h1 : st_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rhc_pkg::*;
    localparam logic [7:0]  RI   = 8'h5a;
    localparam logic [41:0] ONES = '1;
    // Bench drives, design outputs and the reference model state.
    logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        frz_low = 1'h0, park_high = 1'h1, step = 1'h0, clr = 1'h0, ovf = 1'h0;
    logic        pready, pslverr, rd_valid, sbusy, e;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'h23;
    logic [41:0] hit_in = '0;
    logic [12:0] ts = 13'h0;
    rhc_phase_s  ph;
    rhc_out_s    rd_word, got;
    rhc_rec_s    mq[$];
    int          n_errors = 0, checks = 0, nv = 0, cyc = 0, n0;

    rhc_row_ctrl #(.ROW_INDEX(RI)) u_rhc_row_ctrl (.clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .hit_in, .timestamp(ts),
        .latch_freeze_low(frz_low), .latch_park_high(park_high), .slot_phase(ph),
        .rd_word, .rd_valid);
    rhc_seq u_rhc_seq (.clk, .rst, .step, .clr, .ph, .busy(sbusy));

    // Free-running 25 MHz clock.
    initial forever #20 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic print_verdict();
        if (n_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp_reg(input string n, input logic [31:0] x, input logic [31:0] s);
        checks++;
        if (s !== x) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", n, x, s);
        end
    endtask

    task automatic cmp_word(input string n, input rhc_out_s x, input rhc_out_s s);
        checks++;
        if (s !== x) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", n, x, s);
        end
    endtask

    // One bus transfer; the answer is taken at the edge that sees pready.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic stat();
        apb(1'h0, RHC_STAT_OFS, 32'h0);
        cmp_reg("stat", 32'(mq.size()) | (32'(ovf) << 9), q);
    endtask

    // Clear latches, sample hits, freeze, scan; frozen hits must be ignored.
    task automatic scan(input logic [41:0] h, input logic pk);
        @(posedge clk) park_high <= 1'h1;
        @(posedge clk) begin
            park_high <= pk;
            frz_low <= 1'h1;
            hit_in <= h;
            ts <= 13'(rnd());
        end
        @(posedge clk) begin
            park_high <= 1'h0;
            frz_low <= 1'h0;
            hit_in <= 42'({rnd(), rnd()});
        end
        apb(1'h1, RHC_CTRL_OFS, 32'h1);
        apb(1'h0, RHC_STAT_OFS, 32'h0);
        cmp_reg("busy", 32'h1, 32'(q[8]));
        repeat (8) @(posedge clk);
        for (int b = 0; b < RHC_BANKS; b++)
            if (!pk && h[b*6+:6] != 6'h0) begin
                if (mq.size() < RHC_SLOTS) mq.push_back(rhc_rec_s'{ts, 3'(b), h[b*6+:6]});
                else ovf = 1'h1;
            end
        stat();
    endtask

    // Readout strobes are counted and the latest word kept.
    always @(posedge clk) begin
        cyc++;
        if (rd_valid === 1'h1) begin
            nv++;
            got = rd_word;
        end
        if (cyc == 5000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        repeat (8) @(posedge clk);
        apb(1'h0, RHC_CTRL_OFS, 32'h0);
        cmp_reg("ctrl", 32'h0, q);
        apb(1'h0, RHC_ROWID_OFS, 32'h0);
        cmp_reg("rowid", 32'(RI), q);
        apb(1'h0, 8'h10, 32'h0);
        cmp_reg("err", 32'h1, 32'(e));
        cmp_reg("bad_data", 32'h0, q);
        scan(42'({rnd(), rnd()} & {rnd(), rnd()}), 1'h0);
        repeat (3) scan(ONES, 1'h0);
        apb(1'h1, RHC_CLEAR_OFS, 32'h200);
        ovf = 1'h0;
        stat();
        // Newest first, one extra step on an empty store.
        apb(1'h1, RHC_CTRL_OFS, 32'h2);
        apb(1'h0, RHC_CTRL_OFS, 32'h0);
        cmp_reg("ctrl_read", 32'h2, q);
        repeat (RHC_SLOTS + 1) begin
            n0 = nv;
            @(posedge clk) step <= 1'h1;
            @(posedge clk) step <= 1'h0;
            repeat (6) @(posedge clk);
            cmp_reg("steps", 32'(n0 + (mq.size() > 0)), 32'(nv));
            if (mq.size() > 0) cmp_word("word", rhc_out_s'{RI, mq.pop_back()}, got);
        end
        apb(1'h1, RHC_CTRL_OFS, 32'h0);
        scan(ONES, 1'h0);
        @(posedge clk) clr <= 1'h1;
        @(posedge clk) clr <= 1'h0;
        do @(posedge clk); while (sbusy !== 1'h0);
        mq.delete();
        stat();
        scan(ONES, 1'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
